/* File: rtl/lbsdi_map.vh */
// Register offsets, field positions, reset values and counts of the loopback and drop/insert block.
`ifndef LBSDI_MAP_VH
`define LBSDI_MAP_VH

// Register offsets on the plain register port (byte offsets as printed).
`define LBSDI_ADDR_LB_STAT_LO   8'h5C
`define LBSDI_ADDR_LB_STAT_HI   8'h5E
`define LBSDI_ADDR_DROP_SEL     8'h60
`define LBSDI_ADDR_INS_SEL      8'h62
`define LBSDI_ADDR_IRQ_STAT     8'h64
`define LBSDI_ADDR_IRQ_CLR      8'h66
`define LBSDI_ADDR_IRQ_MASK     8'h68

// Widths.
`define LBSDI_ADDR_W            8
`define LBSDI_DATA_W            16
`define LBSDI_PORTS             28
`define LBSDI_CODE_W            5

// Select field positions: A in bits 4..0, B in bits 12..8.
`define LBSDI_SEL_A_LSB         0
`define LBSDI_SEL_B_LSB         8

// Status layout: low register holds ports 1..16, high register ports 17..28.
`define LBSDI_STAT_LO_PORTS     16
`define LBSDI_STAT_HI_PORTS     12

// Interrupt status, clear and mask layout.
`define LBSDI_IRQ_LB_BIT        0

// Reset values.
`define LBSDI_SEL_RESET         16'h0000
`define LBSDI_IRQ_MASK_RESET    16'h0000
`define LBSDI_CODE_RESET        5'h00
`define LBSDI_FLAG_RESET        1'b0

// Port code decode limits.
`define LBSDI_CODE_FIRST        5'h01
`define LBSDI_CODE_LAST         5'h1C

// Consecutive frames needed to set or clear a loopback status bit.
`define LBSDI_LB_FRAMES         3'h5

`endif

/* File: rtl/lbsdi_sync.v */
// Two flip-flop synchroniser for a vector of pins from outside the clock domain.
`timescale 1ns/1ps
module lbsdi_sync #(
  parameter W = 1
) (
  input  wire         core_clk,
  input  wire         rst_n,
  input  wire         ce,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_q;

  // The first stage feeds only the second stage, to contain metastability.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else if (ce) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* File: rtl/lbsdi_lb_det.v */
// Per-port far-end line loopback command detector with five-frame set and clear.
`include "lbsdi_map.vh"
`timescale 1ns/1ps
module lbsdi_lb_det (
  input  wire core_clk,
  input  wire rst_n,
  input  wire ce,
  input  wire frame_tick,
  input  wire c3_inverted,
  output reg  lb_seen_q
);

  reg [2:0] run_q;

  // The run counts frames that disagree with the present state; a frame
  // that agrees restarts it, so only an unbroken run of five flips it.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q     <= 3'h0;
      lb_seen_q <= 1'b0;
    end else if (ce && frame_tick) begin
      if (c3_inverted == lb_seen_q) begin
        run_q <= 3'h0;
      end else if (run_q == `LBSDI_LB_FRAMES - 3'h1) begin
        run_q     <= 3'h0;
        lb_seen_q <= c3_inverted;
      end else begin
        run_q <= run_q + 3'h1;
      end
    end
  end

endmodule

/* File: rtl/lbsdi_top.v */
// Loopback command status, drop/insert port selection and its register port.
//
// Strobed register access was decided locally.
`include "lbsdi_map.vh"
`timescale 1ns/1ps
module lbsdi_top (
  input  wire                       core_clk,
  input  wire                       nrst,
  input  wire                       ce,
  input  wire [`LBSDI_ADDR_W-1:0]   reg_addr,
  input  wire [`LBSDI_DATA_W-1:0]   reg_wdata,
  input  wire                       reg_wr,
  input  wire                       reg_rd,
  output reg  [`LBSDI_DATA_W-1:0]   reg_rdata,
  output reg                        irq,
  input  wire [`LBSDI_PORTS-1:0]    t2_frame_tick,
  input  wire [`LBSDI_PORTS-1:0]    t2_c3_inverted,
  input  wire [`LBSDI_PORTS-1:0]    rx_port_clock,
  input  wire [`LBSDI_PORTS-1:0]    rx_port_data,
  input  wire [`LBSDI_PORTS-1:0]    tx_port_clock_in,
  input  wire [`LBSDI_PORTS-1:0]    tx_port_data_in,
  output reg  [`LBSDI_PORTS-1:0]    tx_port_clock_out,
  output reg  [`LBSDI_PORTS-1:0]    tx_port_data_out,
  output reg                        drop_a_data_out,
  output reg                        drop_a_clock_out,
  output reg                        drop_b_data_out,
  output reg                        drop_b_clock_out,
  input  wire                       insert_a_data_in,
  input  wire                       insert_a_clock_in,
  input  wire                       insert_b_data_in,
  input  wire                       insert_b_clock_in
);

  // Number of synchronised pins: receive and transmit ports plus four insert pins.
  localparam SYNC_W = 4 * `LBSDI_PORTS + 4;

  reg                      rst_meta_q;
  reg                      rst_n_q;
  wire [SYNC_W-1:0]        pins_async;
  wire [SYNC_W-1:0]        pins_s;
  wire [`LBSDI_PORTS-1:0]  rx_clk_s;
  wire [`LBSDI_PORTS-1:0]  rx_dat_s;
  wire [`LBSDI_PORTS-1:0]  tx_clk_s;
  wire [`LBSDI_PORTS-1:0]  tx_dat_s;
  wire                     ins_a_dat_s;
  wire                     ins_a_clk_s;
  wire                     ins_b_dat_s;
  wire                     ins_b_clk_s;
  wire [`LBSDI_PORTS-1:0]  lb_seen;
  reg  [`LBSDI_PORTS-1:0]  lb_seen_prev_q;
  reg  [`LBSDI_CODE_W-1:0] drop_a_code_q;
  reg  [`LBSDI_CODE_W-1:0] drop_b_code_q;
  reg  [`LBSDI_CODE_W-1:0] insert_a_code_q;
  reg  [`LBSDI_CODE_W-1:0] insert_b_code_q;
  reg                      loopback_cmd_irq_mask_q;
  reg                      lb_irq_stat_q;
  reg                      lb_irq_stat_d;
  reg  [`LBSDI_DATA_W-1:0] rdata_d;
  reg                      drop_a_data_d;
  reg                      drop_a_clock_d;
  reg                      drop_b_data_d;
  reg                      drop_b_clock_d;
  reg  [`LBSDI_PORTS-1:0]  tx_clock_d;
  reg  [`LBSDI_PORTS-1:0]  tx_data_d;
  wire                     lb_rise;
  wire                     wr_clr;
  wire [15:0]              stat_lo;
  wire [15:0]              stat_hi;

  // A code names a real port only in the range 1..28.
  function code_valid;
    input [`LBSDI_CODE_W-1:0] code;
    begin
      code_valid = (code >= `LBSDI_CODE_FIRST) && (code <= `LBSDI_CODE_LAST);
    end
  endfunction

  // True when a code selects the given zero-based port index.
  function code_hits;
    input [`LBSDI_CODE_W-1:0] code;
    input [`LBSDI_CODE_W-1:0] idx;
    begin
      code_hits = code_valid(code) && ((code - `LBSDI_CODE_FIRST) == idx);
    end
  endfunction

  // Reset is asserted at once and released through two flip-flops, so all
  // state leaves reset on the same edge.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Every port clock and data pin lives in its own clock domain, so all of
  // them are synchronised; port clocks are far slower than core_clk.
  assign pins_async = {insert_b_clock_in, insert_b_data_in,
                       insert_a_clock_in, insert_a_data_in,
                       tx_port_data_in, tx_port_clock_in,
                       rx_port_data, rx_port_clock};

  lbsdi_sync #(
    .W (SYNC_W)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n_q),
    .ce       (ce),
    .async_in (pins_async),
    .sync_out (pins_s)
  );

  // Split the synchronised vector back into its groups.
  assign rx_clk_s    = pins_s[`LBSDI_PORTS-1:0];
  assign rx_dat_s    = pins_s[2*`LBSDI_PORTS-1:`LBSDI_PORTS];
  assign tx_clk_s    = pins_s[3*`LBSDI_PORTS-1:2*`LBSDI_PORTS];
  assign tx_dat_s    = pins_s[4*`LBSDI_PORTS-1:3*`LBSDI_PORTS];
  assign ins_a_dat_s = pins_s[4*`LBSDI_PORTS];
  assign ins_a_clk_s = pins_s[4*`LBSDI_PORTS+1];
  assign ins_b_dat_s = pins_s[4*`LBSDI_PORTS+2];
  assign ins_b_clk_s = pins_s[4*`LBSDI_PORTS+3];

  // One detector per port, fed by that port's T2 framer on this clock.
  genvar gp;
  generate
    for (gp = 0; gp < `LBSDI_PORTS; gp = gp + 1) begin : g_det
      lbsdi_lb_det u_det (
        .core_clk    (core_clk),
        .rst_n       (rst_n_q),
        .ce          (ce),
        .frame_tick  (t2_frame_tick[gp]),
        .c3_inverted (t2_c3_inverted[gp]),
        .lb_seen_q   (lb_seen[gp])
      );
    end
  endgenerate

  // Live status words, bit n is port n+1 or port n+17; upper bits read zero.
  // Writes never reach these words, so software cannot disturb detection.
  assign stat_lo = lb_seen[`LBSDI_STAT_LO_PORTS-1:0];
  assign stat_hi = {4'h0, lb_seen[`LBSDI_PORTS-1:`LBSDI_STAT_LO_PORTS]};

  // An event is any status bit going from clear to set.
  assign lb_rise = |(lb_seen & ~lb_seen_prev_q);
  assign wr_clr  = reg_wr && (reg_addr == `LBSDI_ADDR_IRQ_CLR) &&
                   reg_wdata[`LBSDI_IRQ_LB_BIT];

  // Sticky event flag: a rise in the same cycle as a clear keeps it set.
  always @* begin
    lb_irq_stat_d = lb_irq_stat_q;
    if (wr_clr) begin
      lb_irq_stat_d = 1'b0;
    end
    if (lb_rise) begin
      lb_irq_stat_d = 1'b1;
    end
  end

  // Register writes; status words have no write path so writes there are lost.
  // Select fields start cleared so nothing is dropped or inserted before setup.
  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      drop_a_code_q           <= `LBSDI_CODE_RESET;
      drop_b_code_q           <= `LBSDI_CODE_RESET;
      insert_a_code_q         <= `LBSDI_CODE_RESET;
      insert_b_code_q         <= `LBSDI_CODE_RESET;
      loopback_cmd_irq_mask_q <= `LBSDI_FLAG_RESET;
      lb_irq_stat_q           <= `LBSDI_FLAG_RESET;
      lb_seen_prev_q          <= {`LBSDI_PORTS{1'b0}};
    end else if (ce) begin
      lb_seen_prev_q <= lb_seen;
      lb_irq_stat_q  <= lb_irq_stat_d;
      if (reg_wr) begin
        case (reg_addr)
          `LBSDI_ADDR_DROP_SEL: begin
            drop_a_code_q <= reg_wdata[`LBSDI_SEL_A_LSB+4:`LBSDI_SEL_A_LSB];
            drop_b_code_q <= reg_wdata[`LBSDI_SEL_B_LSB+4:`LBSDI_SEL_B_LSB];
          end
          `LBSDI_ADDR_INS_SEL: begin
            insert_a_code_q <= reg_wdata[`LBSDI_SEL_A_LSB+4:`LBSDI_SEL_A_LSB];
            insert_b_code_q <= reg_wdata[`LBSDI_SEL_B_LSB+4:`LBSDI_SEL_B_LSB];
          end
          `LBSDI_ADDR_IRQ_MASK: begin
            loopback_cmd_irq_mask_q <= reg_wdata[`LBSDI_IRQ_LB_BIT];
          end
          default: begin
            loopback_cmd_irq_mask_q <= loopback_cmd_irq_mask_q;
          end
        endcase
      end
    end
  end

  // Read multiplexer; unmapped and write-only offsets read zero.
  always @* begin
    rdata_d = 16'h0000;
    case (reg_addr)
      `LBSDI_ADDR_LB_STAT_LO: rdata_d = stat_lo;
      `LBSDI_ADDR_LB_STAT_HI: rdata_d = stat_hi;
      `LBSDI_ADDR_DROP_SEL:   rdata_d = {3'h0, drop_b_code_q, 3'h0, drop_a_code_q};
      `LBSDI_ADDR_INS_SEL:    rdata_d = {3'h0, insert_b_code_q, 3'h0, insert_a_code_q};
      `LBSDI_ADDR_IRQ_STAT:   rdata_d = {15'h0000, lb_irq_stat_q};
      `LBSDI_ADDR_IRQ_MASK:   rdata_d = {15'h0000, loopback_cmd_irq_mask_q};
      default:                rdata_d = 16'h0000;
    endcase
  end

  // Read data stand for one cycle after the strobe, zero otherwise.
  // Holding zero between reads keeps a stale value from being taken twice.
  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // Interrupt is a level while the sticky flag and its mask are both set.
  // Using the next flag value saves one cycle of interrupt latency.
  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= lb_irq_stat_d && loopback_cmd_irq_mask_q;
    end
  end

  // Drop selection; an unused drop port is held low rather than floating so
  // downstream equipment sees a quiet line.
  // A select change takes effect on the next output edge.
  always @* begin
    drop_a_data_d  = 1'b0;
    drop_a_clock_d = 1'b0;
    drop_b_data_d  = 1'b0;
    drop_b_clock_d = 1'b0;
    if (code_valid(drop_a_code_q)) begin
      drop_a_data_d  = rx_dat_s[drop_a_code_q - `LBSDI_CODE_FIRST];
      drop_a_clock_d = rx_clk_s[drop_a_code_q - `LBSDI_CODE_FIRST];
    end
    if (code_valid(drop_b_code_q)) begin
      drop_b_data_d  = rx_dat_s[drop_b_code_q - `LBSDI_CODE_FIRST];
      drop_b_clock_d = rx_clk_s[drop_b_code_q - `LBSDI_CODE_FIRST];
    end
  end

  // Insert selection per transmit port. If the host selects one port for
  // both inserts, insert A wins; that setup is not meant to be used.
  integer ip;
  always @* begin
    tx_clock_d = tx_clk_s;
    tx_data_d  = tx_dat_s;
    for (ip = 0; ip < `LBSDI_PORTS; ip = ip + 1) begin
      if (code_hits(insert_a_code_q, ip[`LBSDI_CODE_W-1:0])) begin
        tx_clock_d[ip] = ins_a_clk_s;
        tx_data_d[ip]  = ins_a_dat_s;
      end else if (code_hits(insert_b_code_q, ip[`LBSDI_CODE_W-1:0])) begin
        tx_clock_d[ip] = ins_b_clk_s;
        tx_data_d[ip]  = ins_b_dat_s;
      end
    end
  end

  // Stream outputs are registered; an unselected insert pin reaches nothing.
  always @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      drop_a_data_out   <= 1'b0;
      drop_a_clock_out  <= 1'b0;
      drop_b_data_out   <= 1'b0;
      drop_b_clock_out  <= 1'b0;
      tx_port_clock_out <= {`LBSDI_PORTS{1'b0}};
      tx_port_data_out  <= {`LBSDI_PORTS{1'b0}};
    end else if (ce) begin
      drop_a_data_out   <= drop_a_data_d;
      drop_a_clock_out  <= drop_a_clock_d;
      drop_b_data_out   <= drop_b_data_d;
      drop_b_clock_out  <= drop_b_clock_d;
      tx_port_clock_out <= tx_clock_d;
      tx_port_data_out  <= tx_data_d;
    end
  end

endmodule

/* File: tb/lbsdi_far.sv */
// Far side: remote T2 mux frames, T1 line clocks and drop/insert gear.
`timescale 1ns/1ps
module lbsdi_far (
  input  logic        core_clk,
  input  logic [27:0] lb_req,
  output logic [27:0] t2_frame_tick,
  output logic [27:0] t2_c3_inverted,
  output logic [27:0] rx_port_clock,
  output logic [27:0] rx_port_data,
  output logic [27:0] tx_port_clock_in,
  output logic [27:0] tx_port_data_in,
  output logic        insert_a_data_in,
  output logic        insert_a_clock_in,
  output logic        insert_b_data_in,
  output logic        insert_b_clock_in
);
  logic        lclk = 1'b0;
  logic [2:0]  fcnt = 3'h0;
  logic [27:0] pat  = 28'h5A3C96E;
  // Line clock runs free at 400 ns, never aligned with a core edge.
  initial begin
    t2_frame_tick = 28'h0;
    t2_c3_inverted = 28'h0;
    #13;
    forever #200 lclk = ~lclk;
  end
  // Receive data walks so that each port carries its own pattern.
  always @(negedge lclk) pat <= {pat[26:0], pat[27]};
  assign rx_port_clock = {28{lclk}};
  assign rx_port_data = pat;
  assign tx_port_clock_in = {28{lclk}};
  assign tx_port_data_in = {28{lclk}};
  // Constant insert data makes a replaced port easy to spot.
  assign insert_a_data_in = 1'b1;
  assign insert_a_clock_in = lclk;
  assign insert_b_data_in = 1'b0;
  assign insert_b_clock_in = ~lclk;
  // One frame per eight cycles; off the tick the C3 flag is inverted.
  always @(posedge core_clk) begin
    fcnt <= fcnt + 3'h1;
    t2_frame_tick <= {28{fcnt == 3'h7}};
    t2_c3_inverted <= (fcnt == 3'h7) ? lb_req : ~lb_req;
  end
endmodule

/* File: tb/lbsdi_chk_properties.sv */
// Assertions on drop/insert routing, select readback and irq masking.
`timescale 1ns/1ps
`include "lbsdi_map.vh"
module lbsdi_chk (
  input logic        core_clk,
  input logic        nrst,
  input logic        ce,
  input logic [7:0]  reg_addr,
  input logic [15:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  input logic        irq,
  input logic [27:0] rx_port_clock,
  input logic [27:0] rx_port_data,
  input logic [27:0] tx_port_clock_in,
  input logic [27:0] tx_port_data_in,
  input logic [27:0] tx_port_clock_out,
  input logic [27:0] tx_port_data_out,
  input logic        drop_a_data_out,
  input logic        drop_a_clock_out,
  input logic        drop_b_data_out,
  input logic        drop_b_clock_out,
  input logic        insert_a_data_in,
  input logic        insert_a_clock_in,
  input logic        insert_b_data_in,
  input logic        insert_b_clock_in
);
  logic [15:0] drop_q;
  logic [15:0] ins_q;
  logic        mask_q;
  logic [3:0]  age_q;
  wire         live = (age_q == 4'hF);
  wire  [4:0]  ac = drop_q[4:0];
  wire  [4:0]  bc = drop_q[12:8];
  wire  [4:0]  ic = ins_q[4:0];
  wire  [4:0]  jc = ins_q[12:8];
  wire         a_ok = (ac >= 5'h01) && (ac <= 5'h1C);
  wire         b_ok = (bc >= 5'h01) && (bc <= 5'h1C);
  wire         i_ok = (ic >= 5'h01) && (ic <= 5'h1C);
  wire         j_ok = (jc >= 5'h01) && (jc <= 5'h1C);
  wire  [15:0] sel_view = (reg_addr == `LBSDI_ADDR_DROP_SEL) ? drop_q : ins_q;
  // Shadows of the writable registers; age gates the pipeline fill after reset.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drop_q <= 16'h0000;
      ins_q <= 16'h0000;
      mask_q <= 1'b0;
      age_q <= 4'h0;
    end else if (ce) begin
      if (!live) age_q <= age_q + 4'h1;
      if (reg_wr && reg_addr == `LBSDI_ADDR_DROP_SEL) drop_q <= reg_wdata & 16'h1F1F;
      if (reg_wr && reg_addr == `LBSDI_ADDR_INS_SEL) ins_q <= reg_wdata & 16'h1F1F;
      if (reg_wr && reg_addr == `LBSDI_ADDR_IRQ_MASK) mask_q <= reg_wdata[0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_a_none;
    live && !a_ok;
  endsequence
  sequence s_b_none;
    live && !b_ok;
  endsequence
  // A code must hold while the three-cycle pin pipeline drains, else the
  // past sample belongs to a different port.
  AST_DROP_A_NONE: assert property (s_a_none [*3] |->
    !drop_a_data_out && !drop_a_clock_out) else $error("drop A driven with no port");
  AST_DROP_B_NONE: assert property (s_b_none [*3] |->
    !drop_b_data_out && !drop_b_clock_out) else $error("drop B driven with no port");
  AST_DROP_A_FOLLOW: assert property ((live && a_ok && $stable(ac)) [*5] |->
    {drop_a_clock_out, drop_a_data_out} == {$past(rx_port_clock[ac - 5'h01], 3),
    $past(rx_port_data[ac - 5'h01], 3)}) else $error("drop A wrong port");
  AST_DROP_B_FOLLOW: assert property ((live && b_ok && $stable(bc)) [*5] |->
    {drop_b_clock_out, drop_b_data_out} == {$past(rx_port_clock[bc - 5'h01], 3),
    $past(rx_port_data[bc - 5'h01], 3)}) else $error("drop B wrong port");
  AST_INS_A: assert property ((live && i_ok && $stable(ic)) [*5] |->
    tx_port_data_out[ic - 5'h01] == $past(insert_a_data_in, 3) &&
    tx_port_clock_out[ic - 5'h01] == $past(insert_a_clock_in, 3)) else $error("insert A lost");
  AST_INS_B: assert property ((live && j_ok && jc != ic && $stable(jc)) [*5] |->
    tx_port_data_out[jc - 5'h01] == $past(insert_b_data_in, 3) &&
    tx_port_clock_out[jc - 5'h01] == $past(insert_b_clock_in, 3)) else $error("insert B lost");
  AST_INS_IDLE: assert property ((live && !i_ok && !j_ok) [*5] |->
    tx_port_data_out == $past(tx_port_data_in, 3) &&
    tx_port_clock_out == $past(tx_port_clock_in, 3)) else $error("idle insert not ignored");
  AST_IRQ_MASKED: assert property ((live && !mask_q) [*2] |-> !irq)
    else $error("irq high while masked");
  AST_SEL_READ: assert property (reg_rd && live && (reg_addr == `LBSDI_ADDR_DROP_SEL ||
    reg_addr == `LBSDI_ADDR_INS_SEL) |=> (reg_rdata & 16'h1F1F) == $past(sel_view))
    else $error("select readback wrong");
endmodule
bind lbsdi_top lbsdi_chk u_chk (.core_clk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .irq, .rx_port_clock, .rx_port_data, .tx_port_clock_in, .tx_port_data_in,
  .tx_port_clock_out, .tx_port_data_out, .drop_a_data_out, .drop_a_clock_out, .drop_b_data_out,
  .drop_b_clock_out, .insert_a_data_in, .insert_a_clock_in, .insert_b_data_in,
  .insert_b_clock_in);

/* File: tb/testbench.sv */
// Self-checking bench: loopback status, drop/insert routing, interrupt.
`timescale 1ns/1ps
module testbench;
  logic        core_clk  = 1'b0;
  logic        nrst      = 1'b0;
  logic        ce        = 1'b1;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [27:0] lb_req    = 28'h0000000;
  logic [15:0] sa, sb, p0;
  int          err_count = 0;
  int          compares  = 0;
  wire  [15:0] reg_rdata;
  wire         irq, drop_a_data_out, drop_a_clock_out, drop_b_data_out, drop_b_clock_out;
  wire         insert_a_data_in, insert_a_clock_in, insert_b_data_in, insert_b_clock_in;
  wire  [27:0] t2_frame_tick, t2_c3_inverted, rx_port_clock, rx_port_data;
  wire  [27:0] tx_port_clock_in, tx_port_data_in, tx_port_clock_out, tx_port_data_out;
  lbsdi_top dut (.core_clk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .t2_frame_tick, .t2_c3_inverted, .rx_port_clock, .rx_port_data, .tx_port_clock_in,
    .tx_port_data_in, .tx_port_clock_out, .tx_port_data_out, .drop_a_data_out,
    .drop_a_clock_out, .drop_b_data_out, .drop_b_clock_out, .insert_a_data_in,
    .insert_a_clock_in, .insert_b_data_in, .insert_b_clock_in);
  lbsdi_far far_end (.core_clk, .lb_req, .t2_frame_tick, .t2_c3_inverted, .rx_port_clock,
    .rx_port_data, .tx_port_clock_in, .tx_port_data_in, .insert_a_data_in,
    .insert_a_clock_in, .insert_b_data_in, .insert_b_clock_in);
  // Free-running core clock at 20 MHz.
  initial forever #25 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe, so look there.
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge core_clk iff t2_frame_tick[0]);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  function automatic logic [15:0] port_on(input int c);
    return (c >= 1 && c <= 28) ? 16'h0001 : 16'h0000;
  endfunction
  function automatic logic [15:0] sel(input int c);
    return {3'h0, 5'(31 - c), 3'h0, 5'(c)};
  endfunction
  task automatic stop_test;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // A hang ends the run as a failure.
  initial begin
    #500000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdc(8'h60, 16'h0000);
    rdc(8'h62, 16'h0000);
    rdc(8'h64, 16'h0000);
    // Ports 1, 16, 17 and 28 run as T1 lines, so their status is meaningful.
    // Requests change just after a frame tick, so no frame in flight is stale.
    wr(8'h68, 16'h0001);
    frames(1);
    lb_req <= 28'h8018001;
    frames(4);
    lb_req <= 28'h0000000;
    frames(1);
    lb_req <= 28'h8018001;
    frames(4);
    rdc(8'h5C, 16'h0000);
    frames(1);
    rdc(8'h5C, 16'h8001);
    rdc(8'h5E, 16'h0801);
    rdc(8'h64, 16'h0001);
    chk(16'(irq), 16'h0001);
    wr(8'h5C, 16'hFFFF);
    wr(8'h66, 16'h0001);
    settle(2);
    chk(16'(irq), 16'h0000);
    rdc(8'h5C, 16'h8001);
    frames(1);
    lb_req <= 28'h0000000;
    frames(4);
    rdc(8'h5E, 16'h0801);
    frames(1);
    rdc(8'h5C, 16'h0000);
    rdc(8'h5E, 16'h0000);
    wr(8'h68, 16'h0000);
    frames(1);
    lb_req <= 28'h0000001;
    frames(5);
    settle(3);
    chk(16'(irq), 16'h0000);
    wr(8'h68, 16'h0001);
    settle(2);
    chk(16'(irq), 16'h0001);
    // Every drop code on A, the mirrored code on B.
    for (int c = 0; c < 32; c++) begin
      wr(8'h60, sel(c));
      rdc(8'h60, sel(c));
      repeat (4) @(posedge core_clk);
      sa = 16'h0000;
      sb = 16'h0000;
      repeat (16) begin
        settle(1);
        sa |= 16'(drop_a_clock_out | drop_a_data_out);
        sb |= 16'(drop_b_clock_out | drop_b_data_out);
      end
      chk(sa, port_on(c));
      chk(sb, port_on(31 - c));
    end
    // B never names the same port as A.
    for (int c = 0; c < 32; c++) begin
      wr(8'h62, sel(c));
      repeat (4) @(posedge core_clk);
      sa = 16'h0001;
      sb = 16'h0000;
      p0 = 16'h0001;
      repeat (16) begin
        settle(1);
        if (port_on(c) == 16'h0001) sa &= 16'(tx_port_data_out[c - 1]);
        if (port_on(31 - c) == 16'h0001) sb |= 16'(tx_port_data_out[30 - c]);
        p0 &= 16'(tx_port_data_out[0]);
      end
      chk(sa, 16'h0001);
      chk(sb, 16'h0000);
      chk(p0, (c == 1) ? 16'h0001 : 16'h0000);
    end
    stop_test();
  end
endmodule
